// >>> verilog/ios_params.svh
// Constants for the I/O module select and table timing block
`ifndef IOS_PARAMS_SVH
`define IOS_PARAMS_SVH

// ==========================================================
// Timing
`define IOS_CLK_PERIOD_NS 10
`define IOS_SECOND_NS 1000000000
`define IOS_SEC_CYCLES (`IOS_SECOND_NS / `IOS_CLK_PERIOD_NS)
// 86400 seconds in a day
`define IOS_DAY_SECONDS 17'h1_5180

// ==========================================================
// Line rates in baud, index order of the rate selector
`define IOS_BAUD_0 18'h0_04B0
`define IOS_BAUD_1 18'h0_0960
`define IOS_BAUD_2 18'h0_12C0
`define IOS_BAUD_3 18'h0_2580
`define IOS_BAUD_4 18'h0_4B00
`define IOS_BAUD_5 18'h0_9600
`define IOS_BAUD_6 18'h1_2A0C
`define IOS_BAUD_7 18'h2_5800
`define IOS_RATE_RST 3'h5

// ==========================================================
// Register byte offsets
`define IOS_OFS_CTRL 8'h00
`define IOS_OFS_INTERVAL 8'h04
`define IOS_OFS_CMD 8'h08
`define IOS_OFS_DATA 8'h0C
`define IOS_OFS_STATUS 8'h10
`define IOS_OFS_FS_PTR 8'h14
`define IOS_OFS_FS_ADDR 8'h18
`define IOS_OFS_FS_RDATA 8'h1C
`define IOS_OFS_TOD 8'h20

// ==========================================================
// Field positions
`define IOS_CTRL_RATE_LSB 0
`define IOS_CTRL_HIRES_BIT 3
`define IOS_CMD_OP_LSB 0
`define IOS_CMD_MOD_LSB 8
`define IOS_CMD_LOC_LSB 16
`define IOS_CMD_TBL_LSB 24
`define IOS_MOD_FIRST 3'h1
`define IOS_MOD_LAST 3'h4
`define IOS_CTRL_RST 32'h0000_0005

`endif

// >>> verilog/ios_pkg.sv
// Types for the I/O module select and table timing block
package ios_pkg;

  // ==========================================================
  // Table pass state
  typedef enum logic [0:0] {
    PASS_IDLE = 1'b0,
    PASS_RUN = 1'b1
  } ios_pass_t;

  // ==========================================================
  // Instruction opcodes
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_SELECT = 3'h1,
    OP_FLAG_SET = 3'h2,
    OP_FLAG_CLR = 3'h3,
    OP_END = 3'h4
  } ios_op_t;

  // ==========================================================
  // Status word layout
  typedef struct packed {
    logic [7:0] skips;
    logic wrapped;
    logic busy;
    logic flag;
    logic [2:0] target;
  } ios_status_t;

  // Byte lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// >>> verilog/ios_rate_div.sv
// Divider that turns the clock into a one-cycle enable pulse
`timescale 1ns/1ns
module ios_rate_div #(
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [WIDTH-1:0] divisor,
  output logic tick
);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic wrap;

  assign wrap = (count_r >= divisor - WIDTH'(1));
  assign count_nxt = wrap ? '0 : count_r + WIDTH'(1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
      tick <= 1'b0;
    end else if (!en) begin
      count_r <= '0;
      tick <= 1'b0;
    end else begin
      count_r <= count_nxt;
      tick <= wrap;
    end
  end

endmodule // ios_rate_div

// >>> verilog/ios_ctrl.sv
// Control-side I/O module selection, link rate and table timing
`timescale 1ns/1ns
`include "ios_params.svh"
module ios_ctrl #(
  parameter int SEC_CYCLES = `IOS_SEC_CYCLES,
  parameter int FS_DEPTH = 64
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic [2:0] MOD_SEL_O,
  output logic TABLE_START_O,
  output logic OUT_FLAG_O,
  output logic PASS_BUSY_O,
  output logic [2:0] LINK_RATE_O,
  output logic LINK_BIT_TICK_O
);

  localparam int PW = $clog2(FS_DEPTH);

  // ==========================================================
  // Bus decode
  logic ack_r;
  logic pend_r;
  logic [31:0] ctrl_r;
  logic [16:0] interval_r;
  logic take;
  logic wr;
  logic stall;
  logic hit_ctrl;
  logic hit_int;
  logic hit_cmd;
  logic hit_data;
  logic hit_addr;
  logic [31:0] rd_mux;

  assign hit_ctrl = (WB_ADR_I == `IOS_OFS_CTRL);
  assign hit_int = (WB_ADR_I == `IOS_OFS_INTERVAL);
  assign hit_cmd = (WB_ADR_I == `IOS_OFS_CMD);
  assign hit_data = (WB_ADR_I == `IOS_OFS_DATA);
  assign hit_addr = (WB_ADR_I == `IOS_OFS_FS_ADDR);
  // Second half of a wide value still pending
  assign stall = pend_r & (hit_data | hit_cmd);
  assign take = WB_CYC_I & WB_STB_I & ~ack_r & ~stall;
  assign wr = take & WB_WE_I;
  assign WB_ACK_O = ack_r;

  // ==========================================================
  // Control fields
  logic hi_res;
  logic compile;
  logic [31:0] int_merged;
  logic [31:0] ctrl_merged;
  assign hi_res = ctrl_r[`IOS_CTRL_HIRES_BIT];
  assign ctrl_merged = ios_pkg::merge(ctrl_r, WB_DAT_I, WB_SEL_I);
  assign int_merged = ios_pkg::merge({15'h0000, interval_r}, WB_DAT_I, WB_SEL_I);
  assign compile = wr & hit_int;

  assign LINK_RATE_O = ctrl_r[`IOS_CTRL_RATE_LSB +: 3];

  // ==========================================================
  // Link bit timing
  logic [31:0] baud_div;
  always_comb begin
    case (LINK_RATE_O)
      3'h0: baud_div = 32'(`IOS_SEC_CYCLES / `IOS_BAUD_0);
      3'h1: baud_div = 32'(`IOS_SEC_CYCLES / `IOS_BAUD_1);
      3'h2: baud_div = 32'(`IOS_SEC_CYCLES / `IOS_BAUD_2);
      3'h3: baud_div = 32'(`IOS_SEC_CYCLES / `IOS_BAUD_3);
      3'h4: baud_div = 32'(`IOS_SEC_CYCLES / `IOS_BAUD_4);
      3'h5: baud_div = 32'(`IOS_SEC_CYCLES / `IOS_BAUD_5);
      3'h6: baud_div = 32'(`IOS_SEC_CYCLES / `IOS_BAUD_6);
      3'h7: baud_div = 32'(`IOS_SEC_CYCLES / `IOS_BAUD_7);
      default: baud_div = 32'(`IOS_SEC_CYCLES / `IOS_BAUD_5);
    endcase
  end

  ios_rate_div #(.WIDTH(32)) u_baud (
    .clk(CLK),
    .rst_n(RST_N),
    .en(1'b1),
    .divisor(baud_div),
    .tick(LINK_BIT_TICK_O)
  );

  logic sec_tick;
  ios_rate_div #(.WIDTH(32)) u_sec (
    .clk(CLK),
    .rst_n(RST_N),
    .en(1'b1),
    .divisor(32'(SEC_CYCLES)),
    .tick(sec_tick)
  );

  // ==========================================================
  // Time of day and start scheduling
  logic [16:0] tod_r;
  logic [16:0] tod_nxt;
  logic [16:0] cnt_r;
  logic [16:0] cnt_nxt;
  logic run_r;
  logic aligned_r;
  logic aligned_new;
  logic fire;
  logic [16:0] new_int;

  assign new_int = int_merged[16:0];
  assign tod_nxt = (tod_r == `IOS_DAY_SECONDS - 17'h0_0001) ? 17'h0_0000 : tod_r + 17'h0_0001;
  assign aligned_new = (new_int != 17'h0_0000) && ((`IOS_DAY_SECONDS % new_int) == 17'h0_0000);
  assign cnt_nxt = (cnt_r == 17'h0_0000) ? interval_r - 17'h0_0001 : cnt_r - 17'h0_0001;
  // Midnight aligned; first whole second otherwise
  assign fire = sec_tick & run_r &
                (aligned_r ? ((tod_nxt % interval_r) == 17'h0_0000) : (cnt_r == 17'h0_0000));

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tod_r <= 17'h0_0000;
      cnt_r <= 17'h0_0000;
      run_r <= 1'b0;
      aligned_r <= 1'b0;
      interval_r <= 17'h0_0000;
    end else if (compile) begin
      interval_r <= new_int;
      run_r <= (new_int != 17'h0_0000);
      aligned_r <= aligned_new;
      cnt_r <= 17'h0_0000;
      if (sec_tick) begin
        tod_r <= tod_nxt;
      end
    end else if (sec_tick) begin
      tod_r <= tod_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================
  // Table pass, module selection and output flag
  ios_pkg::ios_pass_t pass_r;
  ios_pkg::ios_pass_t pass_nxt;
  ios_pkg::ios_op_t op;
  logic [2:0] cmd_mod;
  logic [15:0] id_word;
  logic cmd_ok;
  logic start;
  logic skip;
  logic [7:0] skips_r;
  logic flag_r;

  assign op = ios_pkg::ios_op_t'(WB_DAT_I[`IOS_CMD_OP_LSB +: 3]);
  assign cmd_mod = WB_DAT_I[`IOS_CMD_MOD_LSB +: 3];
  assign id_word = {4'h0, WB_DAT_I[`IOS_CMD_TBL_LSB +: 4], WB_DAT_I[`IOS_CMD_LOC_LSB +: 8]};
  assign cmd_ok = wr & hit_cmd & (pass_r == ios_pkg::PASS_RUN);
  assign start = fire & ~compile & (pass_r == ios_pkg::PASS_IDLE);
  assign skip = fire & ~compile & (pass_r == ios_pkg::PASS_RUN);

  always_comb begin
    case (pass_r)
      ios_pkg::PASS_IDLE: pass_nxt = start ? ios_pkg::PASS_RUN : ios_pkg::PASS_IDLE;
      ios_pkg::PASS_RUN: pass_nxt = (cmd_ok && op == ios_pkg::OP_END) ? ios_pkg::PASS_IDLE
                                                                       : ios_pkg::PASS_RUN;
      default: pass_nxt = ios_pkg::PASS_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pass_r <= ios_pkg::PASS_IDLE;
      skips_r <= 8'h00;
    end else if (compile) begin
      pass_r <= ios_pkg::PASS_IDLE;
      skips_r <= 8'h00;
    end else begin
      pass_r <= pass_nxt;
      if (skip && skips_r != 8'hFF) begin
        skips_r <= skips_r + 8'h01;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      MOD_SEL_O <= `IOS_MOD_FIRST;
    end else if (start) begin
      MOD_SEL_O <= `IOS_MOD_FIRST;
    end else if (cmd_ok && op == ios_pkg::OP_SELECT &&
                 cmd_mod >= `IOS_MOD_FIRST && cmd_mod <= `IOS_MOD_LAST) begin
      MOD_SEL_O <= cmd_mod;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      flag_r <= 1'b0;
    end else if (compile || start || (cmd_ok && op == ios_pkg::OP_END)) begin
      flag_r <= 1'b0;
    end else if (cmd_ok && op == ios_pkg::OP_FLAG_SET) begin
      flag_r <= 1'b1;
    end else if (cmd_ok && op == ios_pkg::OP_FLAG_CLR) begin
      flag_r <= 1'b0;
    end
  end

  // ==========================================================
  // Final storage ring
  logic [15:0] fs_mem [FS_DEPTH];
  logic [PW-1:0] ptr_r;
  logic [PW-1:0] fs_addr_r;
  logic [15:0] pend_word_r;
  logic wrapped_r;
  logic data_ok;
  logic fs_we;
  logic [15:0] fs_wdata;

  assign data_ok = wr & hit_data & flag_r & (pass_r == ios_pkg::PASS_RUN);

  always_comb begin
    fs_we = 1'b0;
    fs_wdata = 16'h0000;
    if (pend_r) begin
      fs_we = 1'b1;
      fs_wdata = pend_word_r;
    end else if (cmd_ok && op == ios_pkg::OP_FLAG_SET) begin
      // Array opens with its id word
      fs_we = 1'b1;
      fs_wdata = id_word;
    end else if (data_ok) begin
      fs_we = 1'b1;
      fs_wdata = hi_res ? WB_DAT_I[31:16] : WB_DAT_I[15:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (fs_we) begin
      fs_mem[ptr_r] <= fs_wdata;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ptr_r <= '0;
      wrapped_r <= 1'b0;
      pend_r <= 1'b0;
      pend_word_r <= 16'h0000;
    end else begin
      pend_r <= data_ok & hi_res;
      if (data_ok) begin
        pend_word_r <= WB_DAT_I[15:0];
      end
      if (fs_we) begin
        ptr_r <= (ptr_r == PW'(FS_DEPTH - 1)) ? '0 : ptr_r + PW'(1);
        if (ptr_r == PW'(FS_DEPTH - 1)) begin
          wrapped_r <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Register write and read back
  ios_pkg::ios_status_t status;
  assign status = '{skips: skips_r, wrapped: wrapped_r, busy: (pass_r == ios_pkg::PASS_RUN),
                    flag: flag_r, target: MOD_SEL_O};

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (WB_ADR_I)
      `IOS_OFS_CTRL: rd_mux = ctrl_r;
      `IOS_OFS_INTERVAL: rd_mux = {15'h0000, interval_r};
      `IOS_OFS_STATUS: rd_mux = {18'h0_0000, status};
      `IOS_OFS_FS_PTR: rd_mux = 32'(ptr_r);
      `IOS_OFS_FS_ADDR: rd_mux = 32'(fs_addr_r);
      `IOS_OFS_FS_RDATA: rd_mux = {16'h0000, fs_mem[fs_addr_r]};
      `IOS_OFS_TOD: rd_mux = {15'h0000, tod_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r <= `IOS_CTRL_RST;
      fs_addr_r <= '0;
      ack_r <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
      TABLE_START_O <= 1'b0;
    end else begin
      ack_r <= take;
      TABLE_START_O <= start;
      if (take && !WB_WE_I) begin
        WB_DAT_O <= rd_mux;
      end
      if (wr && hit_ctrl) begin
        ctrl_r <= {28'h000_0000, ctrl_merged[3:0]};
      end
      if (wr && hit_addr) begin
        fs_addr_r <= WB_DAT_I[PW-1:0];
      end
    end
  end

  assign OUT_FLAG_O = flag_r;
  assign PASS_BUSY_O = (pass_r == ios_pkg::PASS_RUN);

endmodule // ios_ctrl

// >>> test/ios_io_model.sv
// Behavioural far-end I/O module controller on the serial link
`timescale 1ns/1ns
module ios_io_model #(
  parameter logic [2:0] MOD_ID = 3'h2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] mod_sel,
  input wire logic [2:0] link_rate,
  input wire logic bit_tick,
  input wire logic [2:0] io_side_rate_jumper,
  output logic rate_ok,
  output logic long_link_ok,
  output logic [3:0] bit_pos
);
  logic [2:0] own_rate;
  assign own_rate = 3'h7 - io_side_rate_jumper;
  assign rate_ok = (own_rate == link_rate);
  assign long_link_ok = (own_rate <= 3'h4);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_pos <= 4'h0;
    end else if (bit_tick && mod_sel == MOD_ID) begin
      bit_pos <= (bit_pos == 4'h8) ? 4'h0 : bit_pos + 4'h1;
    end
  end
endmodule // ios_io_model

// >>> test/ios_ctrl_asserts.sv
// Assertion checker for the module select and table timing block
`timescale 1ns/1ns
`include "ios_params.svh"
module ios_ctrl_asserts (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic [2:0] MOD_SEL_O,
  input wire logic TABLE_START_O,
  input wire logic OUT_FLAG_O,
  input wire logic PASS_BUSY_O,
  input wire logic [2:0] LINK_RATE_O,
  input wire logic LINK_BIT_TICK_O
);
  localparam logic [17:0] BAUDS [8] = '{`IOS_BAUD_0, `IOS_BAUD_1, `IOS_BAUD_2, `IOS_BAUD_3,
    `IOS_BAUD_4, `IOS_BAUD_5, `IOS_BAUD_6, `IOS_BAUD_7};
  logic [19:0] per_r;
  logic [2:0] rate_r;
  logic tick_ok_r;
  wire logic [19:0] div_exp = 20'(`IOS_SEC_CYCLES / BAUDS[LINK_RATE_O]);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ==========================================================
  // Bit period helper
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      per_r <= 20'h0_0000;
      rate_r <= `IOS_RATE_RST;
      tick_ok_r <= 1'h0;
    end else begin
      per_r <= LINK_BIT_TICK_O ? 20'h0_0001 : per_r + 20'h0_0001;
      rate_r <= LINK_RATE_O;
      tick_ok_r <= (LINK_RATE_O != rate_r) ? 1'h0 : (LINK_BIT_TICK_O | tick_ok_r);
    end
  end
  // ==========================================================
  // Properties
  sequence bus_req_s;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence ack_pulse_s;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  AST_BUS_ACK: assert property (bus_req_s |-> ##[1:2] ack_pulse_s)
    else $error("bus request not answered in time");
  AST_START_MOD1: assert property (TABLE_START_O |-> MOD_SEL_O == `IOS_MOD_FIRST)
    else $error("pass start without module one");
  AST_SEL_CAUSE: assert property ($changed(MOD_SEL_O) |-> TABLE_START_O || WB_ACK_O)
    else $error("module target changed without cause");
  AST_MOD_RANGE: assert property (MOD_SEL_O >= `IOS_MOD_FIRST
    && MOD_SEL_O <= `IOS_MOD_LAST)
    else $error("module target out of range");
  AST_RATE_CAUSE: assert property ($changed(LINK_RATE_O) |-> WB_ACK_O)
    else $error("line rate changed without a write");
  AST_BIT_PERIOD: assert property (LINK_BIT_TICK_O && tick_ok_r && LINK_RATE_O == rate_r
    |-> per_r == div_exp)
    else $error("bit period wrong for rate");
  AST_START_PULSE: assert property (TABLE_START_O |=> !TABLE_START_O)
    else $error("start pulse too long");
  AST_NO_OVERLAP: assert property (TABLE_START_O |-> PASS_BUSY_O && !$past(PASS_BUSY_O))
    else $error("pass started over a running pass");
  AST_FLAG_OPEN: assert property ($rose(OUT_FLAG_O) |-> WB_ACK_O && PASS_BUSY_O)
    else $error("flag raised without instruction");
  AST_FLAG_END: assert property (!PASS_BUSY_O |-> !OUT_FLAG_O)
    else $error("flag outlived its pass");
endmodule // ios_ctrl_asserts
bind ios_ctrl ios_ctrl_asserts u_asserts (.CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
  .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .MOD_SEL_O(MOD_SEL_O),
  .TABLE_START_O(TABLE_START_O), .OUT_FLAG_O(OUT_FLAG_O), .PASS_BUSY_O(PASS_BUSY_O),
  .LINK_RATE_O(LINK_RATE_O), .LINK_BIT_TICK_O(LINK_BIT_TICK_O));

// >>> test/tb.sv
// Self-checking bench for the module select and table timing block
`timescale 1ns/1ns
`include "ios_params.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module tb;
  localparam int SEC = 20;
  logic clk, rst_n, cyc, stb, we, ack, start, flag, busy, tick, rate_ok, long_ok;
  logic [7:0] adr;
  logic [31:0] wdat, dat_o, rd, d2, t0;
  logic [2:0] jmp, m, p0, mod_sel, rate;
  logic [3:0] sel, bpos, b0;
  int fails, check_count, n, seed;
  int cycles = 0;
  ios_ctrl #(.SEC_CYCLES(SEC), .FS_DEPTH(8)) u_dut (.CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .MOD_SEL_O(mod_sel), .TABLE_START_O(start),
    .OUT_FLAG_O(flag), .PASS_BUSY_O(busy), .LINK_RATE_O(rate), .LINK_BIT_TICK_O(tick));
  ios_io_model #(.MOD_ID(3'h1)) u_io (.clk(clk), .rst_n(rst_n), .mod_sel(mod_sel),
    .link_rate(rate), .bit_tick(tick), .io_side_rate_jumper(jmp), .rate_ok(rate_ok),
    .long_link_ok(long_ok), .bit_pos(bpos));
  // ==========================================================
  // Helpers
  function automatic logic [15:0] exp_word(input int k, input logic [31:0] d);
    if (k == 0) begin
      return 16'h0217;
    end
    return (k == 2) ? d[31:16] : d[15:0];
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hF);
    int k;
    k = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'h1 && k < 50);
    if (ack !== 1'h1) fails++;
    rd = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wait_start(output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (start !== 1'h1 && c < 2000);
    if (start !== 1'h1) fails++;
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================
  // Clock and timeout
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      end_of_test();
    end
  end
  // ==========================================================
  // Scenarios
  initial begin
    seed = 32'h0000_5B84;
    fails = 0;
    check_count = 0;
    rst_n = 1'h0;
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 8'h00;
    wdat = 32'h0;
    jmp = 3'h2;
    sel = 4'hF;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    `CHK("rate", `IOS_RATE_RST, rate)
    `CHK("module", `IOS_MOD_FIRST, mod_sel)
    bus(1'h0, `IOS_OFS_CTRL, 32'h0);
    `CHK("ctrl", `IOS_CTRL_RST, rd)
    bus(1'h0, 8'hFC, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    for (int i = 0; i < 8; i++) begin
      bus(1'h1, `IOS_OFS_CTRL, 32'(i));
      jmp <= 3'h7 - 3'(i);
      @(posedge clk);
      `CHK("rate", 3'(i), rate)
      `CHK("match", 1'h1, rate_ok)
      `CHK("long link", i <= 4, long_ok)
    end
    // Byte lane zero off: rate must stay
    bus(1'h1, `IOS_OFS_CTRL, 32'h0, 4'hE);
    bus(1'h0, `IOS_OFS_CTRL, 32'h0);
    `CHK("ctrl lanes", 32'h7, rd)
    repeat (1400) @(posedge clk);
    bus(1'h1, `IOS_OFS_INTERVAL, 32'h1);
    wait_start(n);
    `CHK("first", `IOS_MOD_FIRST, mod_sel)
    `CHK("busy", 1'h1, busy)
    m = 3'h2 + 3'($unsigned($random(seed)) % 3);
    bus(1'h1, `IOS_OFS_CMD, {21'h0, m, 8'h01});
    `CHK("select", m, mod_sel)
    bus(1'h1, `IOS_OFS_CMD, 32'h0000_0501);
    `CHK("bad select", m, mod_sel)
    bus(1'h0, `IOS_OFS_FS_PTR, 32'h0);
    p0 = rd[2:0];
    bus(1'h1, `IOS_OFS_CMD, 32'h0217_0002);
    `CHK("flag", 1'h1, flag)
    d2 = $random(seed);
    bus(1'h1, `IOS_OFS_DATA, d2);
    bus(1'h1, `IOS_OFS_CTRL, 32'h0000_000F);
    bus(1'h1, `IOS_OFS_DATA, d2);
    bus(1'h0, `IOS_OFS_FS_PTR, 32'h0);
    `CHK("pointer", p0 + 3'h4, rd[2:0])
    for (int k = 0; k < 4; k++) begin
      bus(1'h1, `IOS_OFS_FS_ADDR, 32'(p0 + 3'(k)));
      bus(1'h0, `IOS_OFS_FS_RDATA, 32'h0);
      `CHK("storage", exp_word(k, d2), rd[15:0])
    end
    bus(1'h1, `IOS_OFS_CMD, 32'h0000_0003);
    `CHK("flag", 1'h0, flag)
    bus(1'h1, `IOS_OFS_DATA, d2);
    bus(1'h0, `IOS_OFS_FS_PTR, 32'h0);
    `CHK("pointer", p0 + 3'h4, rd[2:0])
    bus(1'h1, `IOS_OFS_CMD, 32'h0217_0002);
    repeat (2) bus(1'h1, `IOS_OFS_DATA, d2);
    bus(1'h0, `IOS_OFS_STATUS, 32'h0);
    `CHK("wrapped", 1'h1, rd[5])
    `CHK("skipped", 1'h1, rd[13:6] != 8'h00)
    `CHK("target", m, rd[2:0])
    `CHK("flag busy", 2'h3, rd[4:3])
    // Oldest word now holds the newest low half
    bus(1'h1, `IOS_OFS_FS_ADDR, 32'(p0));
    bus(1'h0, `IOS_OFS_FS_RDATA, 32'h0);
    `CHK("overwrite", d2[15:0], rd[15:0])
    bus(1'h1, `IOS_OFS_CMD, 32'h0000_0004);
    `CHK("flag end", 1'h0, flag)
    `CHK("busy end", 1'h0, busy)
    wait_start(n);
    `CHK("module", `IOS_MOD_FIRST, mod_sel)
    bus(1'h1, `IOS_OFS_INTERVAL, 32'h3);
    wait_start(n);
    bus(1'h0, `IOS_OFS_TOD, 32'h0);
    `CHK("aligned", 32'h0, rd % 32'h3)
    bus(1'h1, `IOS_OFS_INTERVAL, 32'h7);
    wait_start(n);
    `CHK("first second", 1'h1, n <= SEC + 2)
    bus(1'h0, `IOS_OFS_TOD, 32'h0);
    t0 = rd;
    bus(1'h1, `IOS_OFS_CMD, 32'h0000_0004);
    wait_start(n);
    bus(1'h0, `IOS_OFS_TOD, 32'h0);
    `CHK("interval", 32'h7, rd - t0)
    bus(1'h1, `IOS_OFS_INTERVAL, 32'h0);
    // Nine bit ticks bring the far end back to the same bit
    do @(posedge clk); while (tick !== 1'h1);
    @(posedge clk);
    b0 = bpos;
    repeat (9) begin
      do @(posedge clk); while (tick !== 1'h1);
    end
    @(posedge clk);
    `CHK("bit position", b0, bpos)
    end_of_test();
  end
endmodule // tb
